// *** logic/smap_serial_memory_port.sv ***
// Purpose: Serial slave port giving a host word access to the tag memory
// Assumes: Serial clock idles low (mode 0); memory array held in this block
// Notes:   Link logic runs on sck; status flags come from the clock domain
//
// Summary of operation
// - Transaction opens with 8-bit op-code: 03h reads a word, 02h writes.
// - Any other op-code makes the whole transaction ignored.
// - Chip select rising before the op-code completes executes nothing.
// - A 16-bit word address follows, bits taken on rising serial clock.
// - Top five address bits are disregarded for memory addressing.
// - Read data leaves on the serial output, changing on falling edges.
// - Serial input is ignored while read data is shifted out.
// - Each 16 read clocks advance the address while chip select stays low.
// - Address past the highest word wraps to zero, reads and writes.
// - Raising chip select ends a read and stops output immediately.
// - Reads allowed in user, identifier, product code and lock areas.
// - Read-locked areas return an all-zero word.
// - Killed device ignores read transactions.
// - Write sends op-code, address, then one or more 16-bit words.
// - Each complete written word advances the address; chip select ends.
// - Writes accepted in user area only; outcome goes to error register.
// - Killed device ignores write transactions.
// - Any read or write error stores its code in the error register.
// - A read error returns an all-zero word.
// - Error register sits at word address 8000h, readable by read.
// - Next command with leading address bit zero clears the error register.
// - Error word: code in bits 3..0, upper bits read zero.
`timescale 1ns/1ps
`default_nettype none

module smap_serial_memory_port
  import smap_pkg::*;
#(
  parameter int MEM_ADDR_W = MEM_ADDR_BITS
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  sck,
  input  wire logic                  chip_select_n,
  input  wire logic                  si,
  output logic                       so,
  output logic                       so_oe,
  input  wire logic                  tag_killed,
  input  wire logic                  rf_active,
  input  wire logic                  low_voltage,
  input  wire logic [(2**(MEM_ADDR_W-AREA_SHIFT))-1:0] read_lock,
  output logic                       spi_active,
  output logic [ERR_BITS-1:0]        spi_error,
  output logic                       spi_write_done
);

  localparam int AREAS = 2 ** (MEM_ADDR_W - AREA_SHIFT);
  localparam int WORDS = 2 ** MEM_ADDR_W;

  // Address must leave the select bit free and hold at least two areas
  if (MEM_ADDR_W > ERR_SEL_BIT || MEM_ADDR_W <= AREA_SHIFT) begin : g_bad_width
    $error("MEM_ADDR_W out of range");
  end

  // Frame counters are sized for an 8-bit op-code and 16-bit fields
  if (OPC_BITS != 8 || WORD_BITS != 16 || ADDR_FIELD_BITS != 16) begin : g_bad_frame
    $error("frame geometry not supported");
  end

  logic [WORD_BITS-1:0]  mem [WORDS];

  logic                  frame_rst_n;
  logic [2:0]            stat_m;
  logic [2:0]            stat_s;
  logic [AREAS-1:0]      lock_m;
  logic [AREAS-1:0]      lock_s;
  smap_state_t           state;
  logic                  op_read;
  logic [4:0]            bit_cnt;
  logic [WORD_BITS-1:0]  sh;
  logic [3:0]            bit_idx;
  logic [MEM_ADDR_W-1:0] word_addr;
  logic                  err_sel;
  logic [WORD_BITS-1:0]  rd_word;
  logic [ERR_BITS-1:0]   err;
  logic                  err_tgl;
  logic                  wr_tgl;
  logic [7:0]            opcode;
  logic [WORD_BITS-1:0]  addr_full;
  logic [WORD_BITS-1:0]  data_in;
  logic [MEM_ADDR_W-1:0] next_addr;
  logic                  word_end;
  logic [ERR_BITS-1:0]   wr_fault;
  logic [ERR_BITS-1:0]   rd_pend;
  logic                  cs_m;
  logic                  cs_s;
  logic [2:0]            err_sync;
  logic [2:0]            wr_sync;

  wire killed_s = stat_s[2];
  wire rf_s     = stat_s[1];
  wire lowv_s   = stat_s[0];

  function automatic logic [MEM_ADDR_W-1:0] addr_inc(input logic [MEM_ADDR_W-1:0] a);
    addr_inc = MEM_ADDR_W'(a + 1'b1);
  endfunction

  // Last address edge: word address and first read word are taken here
  function automatic logic addr_end(input smap_state_t s, input logic [4:0] c);
    addr_end = (s == st_addr) && (c == ADDR_LAST_EDGE);
  endfunction

  // Commit decode shared by the array and the done toggle
  function automatic logic write_ok(input smap_state_t         s,
                                    input logic                e,
                                    input logic [ERR_BITS-1:0] f);
    write_ok = (s == st_write) && e && (f == ERR_NONE);
  endfunction

  function automatic logic [ERR_BITS-1:0] read_fault(input logic [MEM_ADDR_W-1:0] a);
    if (lowv_s) begin
      read_fault = ERR_LOW_VOLTAGE;
    end else if (rf_s) begin
      read_fault = ERR_RF_ACTIVE;
    end else if (lock_s[a[MEM_ADDR_W-1:AREA_SHIFT]]) begin
      read_fault = ERR_READ_NG;
    end else begin
      read_fault = ERR_NONE;
    end
  endfunction

  function automatic logic [ERR_BITS-1:0] write_fault(input logic [MEM_ADDR_W-1:0] a,
                                                     input logic                  sel);
    logic [15:0] wide;
    wide = 16'(a);
    if (lowv_s) begin
      write_fault = ERR_LOW_VOLTAGE;
    end else if (rf_s) begin
      write_fault = ERR_RF_ACTIVE;
    end else if (sel || wide < USER_FIRST_WORD || wide > USER_LAST_WORD) begin
      write_fault = ERR_WRITE_NG;
    end else begin
      write_fault = ERR_NONE;
    end
  endfunction

  function automatic logic [WORD_BITS-1:0] read_value(input logic [MEM_ADDR_W-1:0] a,
                                                     input logic                  sel);
    if (sel) begin
      read_value = {{(WORD_BITS-ERR_BITS){1'b0}}, err};
    end else if (read_fault(a) != ERR_NONE) begin
      read_value = '0;
    end else begin
      read_value = mem[a];
    end
  endfunction

  // Gated reset: deselect also aborts a partly shifted word
  // frame restart while deselected
  assign frame_rst_n = rst_b & ~chip_select_n;

  assign opcode    = {sh[6:0], si};
  assign addr_full = {sh[14:0], si};
  assign data_in   = {sh[14:0], si};
  assign next_addr = addr_inc(word_addr);
  assign word_end  = (bit_idx == WORD_LAST_BIT);
  assign wr_fault  = write_fault(word_addr, err_sel);

  // Status levels cross into the link clock
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      stat_m <= 3'h0;
      stat_s <= 3'h0;
      lock_m <= '0;
      lock_s <= '0;
    end else begin
      stat_m <= {tag_killed, rf_active, low_voltage};
      stat_s <= stat_m;
      lock_m <= read_lock;
      lock_s <= lock_m;
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sh <= '0;
    end else if (state != st_read) begin
      sh <= data_in;
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 5'h00;
    end else if (state == st_opcode || state == st_addr) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state   <= st_opcode;
      op_read <= 1'b0;
    end else begin
      case (state)
        st_opcode: begin
          // nothing decided before the last op-code bit
          if (bit_cnt == OPC_LAST_EDGE) begin
            if (killed_s) begin
              state <= st_ignore;
            end else if (opcode == OPC_READ) begin
              state   <= st_addr;
              op_read <= 1'b1;
            end else if (opcode == OPC_WRITE) begin
              state   <= st_addr;
              op_read <= 1'b0;
            end else begin
              state <= st_ignore;
            end
          end
        end
        st_addr: begin
          if (bit_cnt == ADDR_LAST_EDGE) begin
            state <= op_read ? st_read : st_write;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_idx   <= 4'h0;
      word_addr <= '0;
      err_sel   <= 1'b0;
    end else if (addr_end(state, bit_cnt)) begin
      bit_idx   <= 4'h0;
      word_addr <= addr_full[MEM_ADDR_W-1:0];
      err_sel   <= addr_full[ERR_SEL_BIT];
    end else if (state == st_read || state == st_write) begin
      bit_idx <= bit_idx + 4'h1;
      if (word_end) begin
        word_addr <= next_addr;
      end
    end
  end

  // next read word fetched at each word boundary
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_word <= '0;
    end else if (addr_end(state, bit_cnt) && op_read) begin
      rd_word <= read_value(addr_full[MEM_ADDR_W-1:0], addr_full[ERR_SEL_BIT]);
    end else if (state == st_read && word_end) begin
      rd_word <= read_value(next_addr, err_sel);
    end
  end

  // A prefetched word may never be clocked out; its fault waits
  // for the next rising edge so a read ending on a boundary stays clean
  // deferred read fault
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_pend <= ERR_NONE;
    end else if (state == st_read && word_end && !err_sel) begin
      rd_pend <= read_fault(next_addr);
    end else begin
      rd_pend <= ERR_NONE;
    end
  end

  // falling-edge output; serial input unused here
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so <= 1'b0;
    end else if (state == st_read) begin
      so <= rd_word[WORD_LAST_BIT - bit_idx];
    end
  end

  assign so_oe = (state == st_read) & ~chip_select_n;

  // Error register outlives frames, so the global reset clears it and the frame reset does not
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      err     <= ERR_RESET;
      err_tgl <= 1'b0;
    end else if (state == st_addr && bit_cnt == ADDR_FIRST_EDGE && !si) begin
      err     <= ERR_NONE;
      err_tgl <= ~err_tgl;
    end else if (addr_end(state, bit_cnt) && op_read &&
                 !addr_full[ERR_SEL_BIT] &&
                 read_fault(addr_full[MEM_ADDR_W-1:0]) != ERR_NONE) begin
      err     <= read_fault(addr_full[MEM_ADDR_W-1:0]);
      err_tgl <= ~err_tgl;
    end else if (state == st_read && rd_pend != ERR_NONE) begin
      // fault of a word the host has begun to clock
      err     <= rd_pend;
      err_tgl <= ~err_tgl;
    end else if (state == st_write && word_end) begin
      err     <= wr_fault;
      err_tgl <= ~err_tgl;
    end
  end

  always_ff @(posedge sck) begin
    if (write_ok(state, word_end, wr_fault)) begin
      mem[word_addr] <= data_in;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      wr_tgl <= 1'b0;
    end else if (write_ok(state, word_end, wr_fault)) begin
      wr_tgl <= ~wr_tgl;
    end
  end

  // Chip select seen as a level in the system clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_m       <= 1'b1;
      cs_s       <= 1'b1;
      spi_active <= 1'b0;
    end else begin
      cs_m       <= chip_select_n;
      cs_s       <= cs_m;
      spi_active <= ~cs_s;
    end
  end

  // Error word is stable for many link clocks after its toggle flips
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_sync  <= 3'h0;
      spi_error <= ERR_RESET;
    end else begin
      err_sync <= {err_sync[1:0], err_tgl};
      if (err_sync[2] != err_sync[1]) begin
        spi_error <= err;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_sync        <= 3'h0;
      spi_write_done <= 1'b0;
    end else begin
      wr_sync        <= {wr_sync[1:0], wr_tgl};
      spi_write_done <= wr_sync[2] ^ wr_sync[1];
    end
  end

endmodule

`default_nettype wire

// *** pkg/smap_pkg.sv ***
// Purpose: Shared constants and types of the serial memory access port
// Assumes: Word-organised memory, 16-bit words, 8-bit op-code, 16-bit address field
// Notes:   Error codes occupy the low four bits of the error information word
package smap_pkg;

  localparam int          OPC_BITS        = 8;
  localparam int          ADDR_FIELD_BITS = 16;
  localparam int          WORD_BITS       = 16;
  localparam int          ERR_BITS        = 4;
  localparam int          MEM_ADDR_BITS   = 11;
  localparam int          AREA_SHIFT      = 4;
  localparam int          ERR_SEL_BIT     = 15;

  localparam logic [7:0]  OPC_READ        = 8'h03;
  localparam logic [7:0]  OPC_WRITE       = 8'h02;

  // Rising-edge counts inside a frame
  localparam logic [4:0]  OPC_LAST_EDGE   = 5'h07;
  localparam logic [4:0]  ADDR_FIRST_EDGE = 5'h08;
  localparam logic [4:0]  ADDR_LAST_EDGE  = 5'h17;
  localparam logic [3:0]  WORD_LAST_BIT   = 4'hf;

  localparam logic [15:0] ERR_REG_ADDR    = 16'h8000;
  localparam logic [15:0] USER_FIRST_WORD = 16'h0150;
  localparam logic [15:0] USER_LAST_WORD  = 16'h07ff;

  localparam logic [3:0]  ERR_LOW_VOLTAGE = 4'h8;
  localparam logic [3:0]  ERR_WRITE_NG    = 4'h4;
  localparam logic [3:0]  ERR_READ_NG     = 4'h2;
  localparam logic [3:0]  ERR_RF_ACTIVE   = 4'h1;
  localparam logic [3:0]  ERR_NONE        = 4'h0;
  localparam logic [3:0]  ERR_RESET       = 4'h0;

  typedef enum logic [2:0] {
    st_opcode,
    st_addr,
    st_read,
    st_write,
    st_ignore
  } smap_state_t;

endpackage

// *** tb/serial_memory_access_port_tb.sv ***
// Purpose: Self-checking bench of the serial memory access port
// Assumes: 4 ns system clock, host frames at 15 ns serial clock
// Notes:   Reference memory holds only words the bench wrote
`timescale 1ns/1ps
`default_nettype none
module serial_memory_access_port_tb;
  import smap_pkg::*;
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         kil = 1'b0;
  logic         rf = 1'b0;
  logic         lv = 1'b0;
  logic [127:0] lock = '0;
  logic [3:0]   e_err = 4'h0;
  logic [15:0]  mem[int];
  wire          sck, cs_n, si, so, so_oe, wdone;
  wire  [3:0]   err;
  // Released line toggles so stale data cannot match
  wire          so_w = so_oe ? so : clock;
  int           mismatches = 0, n_tests = 0, ndone = 0, e_done = 0, cyc = 0;
  smap_serial_memory_port dut_u (.clock(clock), .rst_b(rst_b), .sck(sck),
    .chip_select_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .tag_killed(kil),
    .rf_active(rf), .low_voltage(lv), .read_lock(lock), .spi_active(),
    .spi_error(err), .spi_write_done(wdone));
  smap_host_model host_u (.sck(sck), .chip_select_n(cs_n), .si(si), .so(so_w));
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (wdone === 1'b1) ndone++;
    if (cyc == 20000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] op, input logic [15:0] ad, input int nw,
                      input int lim);
    logic [31:0] wd, rd, er;
    logic [10:0] a;
    logic [15:0] v;
    logic        ok;
    @(posedge clock) #1;
    wd = $urandom;
    er = '0;
    a = ad[10:0];
    ok = (op == OPC_READ || op == OPC_WRITE) && lim > 8 && !kil;
    host_u.frame(op, ad, wd, nw, lim, rd);
    if (ok && !ad[15]) e_err = ERR_NONE;
    for (int i = 0; i < nw && 40 + 16 * i <= lim; i++) begin
      v = (i == 0) ? wd[31:16] : wd[15:0];
      if (ok && op == OPC_WRITE) begin
        e_err = lv ? ERR_LOW_VOLTAGE : rf ? ERR_RF_ACTIVE
              : (!ad[15] && a >= USER_FIRST_WORD[10:0]) ? ERR_NONE : ERR_WRITE_NG;
        if (e_err == ERR_NONE) begin
          mem[a] = v;
          e_done++;
        end
      end else if (ok && !ad[15] && (lv || rf || lock[a[10:4]])) begin
        e_err = lv ? ERR_LOW_VOLTAGE : rf ? ERR_RF_ACTIVE : ERR_READ_NG;
        v = 16'h0;
      end else begin
        v = ad[15] ? {12'h0, e_err} : mem[a];
      end
      er = {er[15:0], v};
      a = a + 11'h1;
    end
    if (ok && op == OPC_READ) begin
      check(rd[15:0], er[15:0]);
      if (nw == 2) check(rd[31:16], er[31:16]);
    end
    repeat (12) @(posedge clock);
    check({12'h0, err}, {12'h0, e_err});
    check(16'(ndone), 16'(e_done));
    $display("test %h %h done", op, ad);
  endtask
  initial begin
    void'($urandom(51071));
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    xfer(OPC_WRITE, {1'b0, 4'($urandom), 11'h150}, 2, 99);
    xfer(OPC_READ, 16'h7950, 2, 99);
    xfer(OPC_READ, ERR_REG_ADDR, 1, 99);
    xfer(OPC_WRITE, 16'h0010, 1, 99);
    xfer(OPC_READ, ERR_REG_ADDR, 2, 99);
    xfer(OPC_READ, 16'h0151, 1, 99);
    xfer(OPC_WRITE, ERR_REG_ADDR, 1, 99);
    xfer(OPC_WRITE, 16'h0154, 2, 45);
    xfer(OPC_WRITE, 16'h07ff, 2, 99);
    @(posedge clock) #1 lock[7'h00] = 1'b1;
    xfer(OPC_READ, 16'h07ff, 1, 99);
    xfer(OPC_READ, 16'h07ff, 2, 99);
    @(posedge clock) #1 lock[7'h15] = 1'b1;
    xfer(OPC_READ, 16'h0150, 2, 99);
    @(posedge clock) #1 lock = '0;
    rf = 1'b1;
    xfer(OPC_WRITE, 16'h0152, 1, 99);
    xfer(OPC_READ, 16'h0150, 1, 99);
    @(posedge clock) #1 rf = 1'b0;
    lv = 1'b1;
    xfer(OPC_READ, 16'h0150, 1, 99);
    xfer(OPC_WRITE, 16'h0153, 1, 99);
    @(posedge clock) #1 lv = 1'b0;
    kil = 1'b1;
    xfer(OPC_WRITE, 16'h0150, 1, 99);
    xfer(OPC_READ, 16'h0150, 1, 99);
    @(posedge clock) #1 kil = 1'b0;
    xfer(8'h05, 16'h0150, 1, 99);
    xfer(OPC_WRITE, 16'h0150, 1, 5);
    xfer(OPC_READ, 16'h0150, 2, 99);
    conclude();
  end
endmodule
`default_nettype wire

// *** tb/smap_host_model.sv ***
// Purpose: Host serial master sending frames to the port
// Assumes: Mode 0; serial clock stands still between frames
// Notes:   Serial input is inverted once released
`timescale 1ns/1ps
`default_nettype none
module smap_host_model
  import smap_pkg::*;
(
  output logic      sck,
  output logic      chip_select_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    si = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input logic [15:0] ad,
                       input logic [31:0] wd, input int nw, input int lim,
                       output logic [31:0] rd);
    logic [55:0] bits;
    bits = {op, ad, wd};
    rd = '0;
    chip_select_n = 1'b0;
    for (int k = 0; k < 24 + 16 * nw && k != lim; k++) begin
      si = (k > 23 && op == OPC_READ) ? 1'($urandom) : bits[55-k];
      #7.5 sck = 1'b1;
      rd = {rd[30:0], so};
      #7.5 sck = 1'b0;
    end
    #7.5 chip_select_n = 1'b1;
    si = ~si;
    #30;
  endtask
endmodule
`default_nettype wire

// *** tb/smap_port_assertions.sv ***
// Purpose: Pin-level checks of the serial memory port
// Assumes: Mode 0 serial clock, frames restart on chip select high
// Notes:   Edge counter tracks the position in the frame
`timescale 1ns/1ps
`default_nettype none
module smap_port_checker
  import smap_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic                sck,
  input wire logic                chip_select_n,
  input wire logic                si,
  input wire logic                so,
  input wire logic                so_oe,
  input wire logic                tag_killed,
  input wire logic                spi_active,
  input wire logic [ERR_BITS-1:0] spi_error,
  input wire logic                spi_write_done
);
  logic [5:0] cnt;
  logic [7:0] opc;
  logic       kill0;
  // Saturates so that long reads keep a valid count
  always_ff @(posedge sck or posedge chip_select_n or negedge rst_b) begin
    if (chip_select_n || !rst_b) begin
      cnt <= 6'h00;
    end else if (cnt != 6'h3f) begin
      cnt <= cnt + 6'h01;
    end
  end
  always_ff @(posedge sck) begin
    if (cnt < 6'h08) begin
      opc <= {opc[6:0], si};
    end
    if (cnt == 6'h00) begin
      kill0 <= tag_killed;
    end
  end
  property p_oe_cs;
    @(posedge clock) disable iff (!rst_b) chip_select_n |-> !so_oe;
  endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("output enabled while deselected");
  property p_act;
    @(posedge clock) disable iff (!rst_b) chip_select_n [*5] |-> !spi_active;
  endproperty
  a_act: assert property (p_act)
    else $error("active flag after deselect");
  property p_act_on;
    @(posedge clock) disable iff (!rst_b) !chip_select_n [*5] |-> spi_active;
  endproperty
  a_act_on: assert property (p_act_on)
    else $error("active flag missing while selected");
  property p_so_fall;
    @(posedge clock) disable iff (!rst_b) $changed(so) |-> !sck;
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("output changed with serial clock high");
  property p_oe_read;
    @(posedge sck) disable iff (chip_select_n || !rst_b)
      so_oe |-> cnt >= 6'h18 && opc == OPC_READ;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("output driven outside read data");
  property p_oe_on;
    @(posedge sck) disable iff (chip_select_n || !rst_b)
      cnt == 6'h18 && opc == OPC_READ && !kill0 |-> so_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("read data not driven");
  property p_kill;
    @(posedge sck) disable iff (chip_select_n || !rst_b) kill0 && cnt > 6'h01 |-> !so_oe;
  endproperty
  a_kill: assert property (p_kill)
    else $error("killed device drove output");
  property p_wr;
    @(posedge clock) disable iff (!rst_b) spi_write_done |=> !spi_write_done;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write pulse longer than one cycle");
  property p_err;
    @(posedge clock) disable iff (!rst_b) spi_error inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  endproperty
  a_err: assert property (p_err)
    else $error("illegal error code");
  c_read: cover property (@(posedge sck) cnt == 6'h18 && so_oe);
  c_wdone: cover property (@(posedge clock) spi_write_done);
  c_err4: cover property (@(posedge clock) spi_error == ERR_WRITE_NG);
endmodule
bind smap_serial_memory_port smap_port_checker chk_u (.clock(clock), .rst_b(rst_b),
  .sck(sck), .chip_select_n(chip_select_n), .si(si), .so(so), .so_oe(so_oe),
  .tag_killed(tag_killed), .spi_active(spi_active), .spi_error(spi_error),
  .spi_write_done(spi_write_done));
`default_nettype wire
